// ### hdl/cycle_steal_address_control.sv
`timescale 1ns/1ps
// Behaviour
// - sequencer makes set, increment, reset of address
// - miscompare when data bus differs from buffer
// - lines 0,1 low: increment at X4
// - line0 high, 1,2 low: increment at X4
// - lines 0,1 high: increment at X4
// - line0 low, line2 high: in bus to out
// - line0 low, line1 high: clear at phase3
// - line0 low, line1 high: load phases 1-4
// - chain check mismatch sets flag at T6
// - chain check mismatch signals error at phase5
// - dash positions are don't care
// - address to buffer X1, buffer addresses X2-X7
module cycle_steal_address_control (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // adapter side
  input wire logic cs_request,
  input wire logic [2:0] cs_ctl,
  input wire logic [15:0] in_bus,
  input wire logic [15:0] io_data,
  // storage side
  input wire logic [15:0] chan_data_bus,
  output logic [15:0] storage_addr,
  output logic [15:0] out_bus,
  output logic [15:0] xfer_reg,
  // status
  output logic cs_active,
  output logic [2:0] t_phase,
  output logic [2:0] x_phase,
  output logic addr_miscompare,
  output logic check_error,
  output logic address_mismatch_flag
);

  cs_pkg::reg_req_s req;
  cs_pkg::cs_ctl_s ctl_reg;
  logic enable_reg;
  logic cs_active_reg;
  logic [15:0] channel_address_reg;
  logic [15:0] channel_address_next;
  logic [15:0] channel_address_buffer;
  logic [15:0] buffer_next;
  logic [15:0] storage_addr_reg;
  logic [15:0] out_bus_reg;
  logic [15:0] xfer_reg_q;
  logic [15:0] rdata_reg;
  logic check_error_reg;
  logic mismatch_pending_reg;
  logic mismatch_flag_reg;
  logic t_wrap;
  logic x_wrap;
  logic x_advance;
  logic cs_start;
  logic [2:0] tx_phase;
  logic [2:0] x_phase_next;
  logic sel_increment;
  logic sel_gate_bus;
  logic sel_set_reset;
  logic sel_io_gate;
  logic sel_chain_check;
  logic do_increment;
  logic do_reset;
  logic do_set;
  logic do_check_error;
  logic do_flag_set;
  logic wr_ctrl;
  logic wr_status;
  logic wr_addr;
  logic flag_clear;
  logic [15:0] rd_mux;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // processor ring is blocked while a steal owns the cycle
  phase_ring #(.W(cs_pkg::PHASE_W)) t_ring (
    .core_clk(core_clk),
    .rstn(rstn),
    .advance(!cs_active_reg),
    .phase(t_phase),
    .wrap(t_wrap)
  );

  // channel ring runs only while a steal is active, through back to back steals too
  phase_ring #(.W(cs_pkg::PHASE_W)) x_ring (
    .core_clk(core_clk),
    .rstn(rstn),
    .advance(x_advance),
    .phase(x_phase),
    .wrap(x_wrap)
  );

  // a steal starts after T7; back to back steals skip T time
  assign cs_start = t_wrap && cs_request && enable_reg;
  assign x_advance = cs_active_reg;
  assign x_phase_next = x_advance ? x_phase + 3'h1 : x_phase;
  assign tx_phase = cs_active_reg ? x_phase : t_phase;

  // lines registered every cycle, so each decode follows them one phase late
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= cs_ctl;
    end
  end

  // decode of the control lines; a dash is left out of the term
  assign sel_increment = (!ctl_reg.line0 && !ctl_reg.line1)
    || (ctl_reg.line0 && !ctl_reg.line1 && !ctl_reg.line2)
    || (ctl_reg.line0 && ctl_reg.line1);
  assign sel_gate_bus = !ctl_reg.line0 && ctl_reg.line2;
  assign sel_set_reset = !ctl_reg.line0 && ctl_reg.line1;
  assign sel_io_gate = !ctl_reg.line1 && ctl_reg.line2;
  assign sel_chain_check = ctl_reg.line0 && ctl_reg.line1 && !ctl_reg.line2;

  // address compare against the buffer
  assign addr_miscompare = sel_chain_check && (chan_data_bus != channel_address_buffer);

  // actions qualified by phase
  assign do_increment = cs_active_reg && (x_phase == cs_pkg::PH_4) && sel_increment;
  assign do_reset = sel_set_reset && (tx_phase == cs_pkg::PH_3);
  assign do_set = sel_set_reset && (tx_phase >= cs_pkg::PH_1) && (tx_phase <= cs_pkg::PH_4);
  assign do_check_error = addr_miscompare && (tx_phase == cs_pkg::PH_5);
  assign do_flag_set = mismatch_pending_reg && !cs_active_reg && (t_phase == cs_pkg::PH_6);

  // set ORs the data bus in, so reset then set leaves the bus value
  always_comb begin
    channel_address_next = channel_address_reg;
    if (do_increment) begin
      channel_address_next = channel_address_reg + 16'h0001;
    end else if (do_reset || do_set) begin
      channel_address_next = (do_reset ? 16'h0000 : channel_address_reg) | chan_data_bus;
    end else if (wr_addr && !cs_active_reg) begin
      channel_address_next = req.wdata;
    end
  end

  // buffer takes the address at X1 so the register may then count
  assign buffer_next = (cs_active_reg && x_phase == cs_pkg::PH_1) ?
    channel_address_reg : channel_address_buffer;

  // storage addressed from the register early, from the buffer X2 on
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      storage_addr_reg <= cs_pkg::ADDR_RESET;
    end else if (x_phase_next <= cs_pkg::PH_1) begin
      storage_addr_reg <= channel_address_next;
    end else begin
      storage_addr_reg <= buffer_next;
    end
  end

  // address register and buffer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      channel_address_reg <= cs_pkg::ADDR_RESET;
      channel_address_buffer <= cs_pkg::ADDR_RESET;
    end else begin
      channel_address_reg <= channel_address_next;
      channel_address_buffer <= buffer_next;
    end
  end

  // cycle-steal state: a steal lasts one X cycle unless renewed
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_active_reg <= 1'b0;
    end else if (cs_start) begin
      cs_active_reg <= 1'b1;
    end else if (x_wrap) begin
      cs_active_reg <= cs_request && enable_reg;
    end
  end

  // data gating during the steal
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      out_bus_reg <= cs_pkg::DATA_RESET;
      xfer_reg_q <= cs_pkg::DATA_RESET;
    end else begin
      if (cs_active_reg && sel_gate_bus) begin
        out_bus_reg <= in_bus;
      end
      if (cs_active_reg && x_phase == cs_pkg::PH_3 && sel_io_gate) begin
        xfer_reg_q <= io_data;
      end
    end
  end

  // mismatch seen in a steal waits for the next T6
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      check_error_reg <= 1'b0;
      mismatch_pending_reg <= 1'b0;
    end else begin
      check_error_reg <= do_check_error;
      if (do_check_error) begin
        mismatch_pending_reg <= 1'b1;
      end else if (do_flag_set) begin
        mismatch_pending_reg <= 1'b0;
      end
    end
  end

  // sticky flag; a set in the clearing cycle wins
  assign flag_clear = wr_status && req.wdata[cs_pkg::STATUS_MISMATCH_BIT];
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mismatch_flag_reg <= 1'b0;
    end else if (do_flag_set) begin
      mismatch_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      mismatch_flag_reg <= 1'b0;
    end
  end

  // register decode
  assign wr_ctrl = req.wr && (req.addr == cs_pkg::OFS_CTRL);
  assign wr_status = req.wr && (req.addr == cs_pkg::OFS_STATUS);
  assign wr_addr = req.wr && (req.addr == cs_pkg::OFS_ADDR);

  // enable only gates new steals, a running one completes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= cs_pkg::CTRL_ENABLE_RESET;
    end else if (wr_ctrl) begin
      enable_reg <= req.wdata[cs_pkg::CTRL_ENABLE_BIT];
    end
  end

  // read mux; unmapped offsets read zero
  assign rd_mux = (req.addr == cs_pkg::OFS_CTRL) ? {15'h0000, enable_reg} :
    (req.addr == cs_pkg::OFS_STATUS) ?
      {13'h0000, mismatch_pending_reg, cs_active_reg, mismatch_flag_reg} :
    (req.addr == cs_pkg::OFS_ADDR) ? channel_address_reg :
    (req.addr == cs_pkg::OFS_BUFFER) ? channel_address_buffer : 16'h0000;

  // read data stand only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_reg <= cs_pkg::DATA_RESET;
    end else if (req.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // outputs
  assign reg_rdata = rdata_reg;
  assign storage_addr = storage_addr_reg;
  assign out_bus = out_bus_reg;
  assign xfer_reg = xfer_reg_q;
  assign cs_active = cs_active_reg;
  assign check_error = check_error_reg;
  assign address_mismatch_flag = mismatch_flag_reg;

  // checks next to the logic they guard
  a_incr_at_x4: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && x_phase == cs_pkg::PH_4 && sel_increment)
      |=> channel_address_reg == 16'($past(channel_address_reg) + 16'h0001))
    else $error("address register did not increment at X4");

  a_no_incr_else: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && x_phase != cs_pkg::PH_4 && !sel_set_reset && !req.wr)
      |=> channel_address_reg == $past(channel_address_reg))
    else $error("address register moved outside its phases");

  a_gate_in_bus: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && !ctl_reg.line0 && ctl_reg.line2) |=> out_bus == $past(in_bus))
    else $error("in bus not gated to out bus");

  a_reset_load: assert property (@(posedge core_clk) disable iff (!rstn)
    (sel_set_reset && tx_phase == cs_pkg::PH_3 && !do_increment)
      |=> channel_address_reg == $past(chan_data_bus))
    else $error("address register not cleared and loaded at phase 3");

  a_set_or: assert property (@(posedge core_clk) disable iff (!rstn)
    (sel_set_reset && tx_phase == cs_pkg::PH_1 && !do_increment)
      |=> channel_address_reg == ($past(channel_address_reg) | $past(chan_data_bus)))
    else $error("address register not set at phase 1");

  a_io_to_xfer: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && x_phase == cs_pkg::PH_3 && !ctl_reg.line1 && ctl_reg.line2)
      |=> xfer_reg == $past(io_data))
    else $error("io data not gated at X3");

  a_check_error: assert property (@(posedge core_clk) disable iff (!rstn)
    (sel_chain_check && tx_phase == cs_pkg::PH_5
      && chan_data_bus != channel_address_buffer) |=> check_error ##1 !check_error)
    else $error("check error not a single pulse after phase 5");

  a_flag_at_t6: assert property (@(posedge core_clk) disable iff (!rstn)
    (mismatch_pending_reg && !cs_active_reg && t_phase == cs_pkg::PH_6)
      |=> address_mismatch_flag && !mismatch_pending_reg)
    else $error("mismatch flag not set at T6");

  a_buffer_x1: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && x_phase == cs_pkg::PH_1)
      |=> channel_address_buffer == $past(channel_address_reg))
    else $error("buffer not loaded at X1");

  a_addr_source: assert property (@(posedge core_clk) disable iff (!rstn)
    (cs_active_reg && x_phase >= cs_pkg::PH_2) |-> storage_addr == channel_address_buffer)
    else $error("storage not addressed from buffer after X2");

endmodule

// ### hdl/cs_pkg.sv
package cs_pkg;

  // word and phase widths
  localparam int WORD_W = 16;
  localparam int PHASE_W = 3;
  localparam int REG_ADDR_W = 4;

  // clock phase numbers, both rings count 0..7
  localparam logic [2:0] PH_0 = 3'h0;
  localparam logic [2:0] PH_1 = 3'h1;
  localparam logic [2:0] PH_2 = 3'h2;
  localparam logic [2:0] PH_3 = 3'h3;
  localparam logic [2:0] PH_4 = 3'h4;
  localparam logic [2:0] PH_5 = 3'h5;
  localparam logic [2:0] PH_6 = 3'h6;
  localparam logic [2:0] PH_LAST = 3'h7;

  // register offsets (word index)
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_ADDR = 4'h2;
  localparam logic [3:0] OFS_BUFFER = 4'h3;

  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int STATUS_MISMATCH_BIT = 0;
  localparam int STATUS_ACTIVE_BIT = 1;
  localparam int STATUS_PENDING_BIT = 2;

  // reset values
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic CTRL_ENABLE_RESET = 1'b0;

  // the three cycle-steal control lines from the adapter
  typedef struct packed {
    logic line0;
    logic line1;
    logic line2;
  } cs_ctl_s;

  // one register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ### hdl/phase_ring.sv
`timescale 1ns/1ps
// eight-phase clock ring, advances only when told to
module phase_ring #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic advance,
  // phase state
  output logic [W-1:0] phase,
  output logic wrap
);

  logic [W-1:0] phase_reg;
  logic [W-1:0] phase_next;

  // wrap marks the last phase being left
  assign wrap = advance && (phase_reg == {W{1'b1}});
  assign phase_next = advance ? phase_reg + {{(W-1){1'b0}}, 1'b1} : phase_reg;
  assign phase = phase_reg;

  // held still while not advancing
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_reg <= '0;
    end else begin
      phase_reg <= phase_next;
    end
  end

endmodule

// ### dv/adapter_model.sv
`timescale 1ns/1ps
// behavioural adapter: asks for a steal and holds its control lines
module adapter_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // bench commands
  input wire logic start,
  input wire logic [2:0] lines,
  input wire logic [15:0] word,
  // channel side
  input wire logic cs_active,
  output logic cs_request,
  output logic [2:0] cs_ctl,
  output logic [15:0] in_bus,
  output logic [15:0] io_data
);
  // request held until the channel takes the cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cs_request <= 1'b0;
    end else if (start) begin
      cs_request <= 1'b1;
    end else if (cs_active) begin
      cs_request <= 1'b0;
    end
  end
  // action select, steady across the whole steal
  assign cs_ctl = lines;
  // idle data inverted so a stale word never passes for a fresh one
  assign in_bus = (cs_request | cs_active) ? word : ~word;
  assign io_data = (cs_request | cs_active) ? word ^ 16'h5a5a : ~word;
endmodule

// ### dv/test_cycle_steal_address_control.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
// directed bench: registers, decode table, set/reset and chain check
module test_cycle_steal_address_control;
  logic core_clk, rstn, reg_wr, reg_rd, start, cs_request, cs_active;
  logic check_error, address_mismatch_flag, addr_miscompare;
  logic [3:0] reg_addr;
  logic [2:0] lines, cs_ctl, t_phase, x_phase;
  logic [15:0] reg_wdata, reg_rdata, word, in_bus, io_data, chan_data_bus, storage_addr;
  logic [15:0] out_bus, xfer_reg, exp_addr, exp_buf, exp_out, exp_x, v;
  int failures = 0;
  int n_compared = 0;
  int errs;
  cycle_steal_address_control uut (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .cs_request, .cs_ctl, .in_bus, .io_data, .chan_data_bus,
    .storage_addr, .out_bus, .xfer_reg, .cs_active, .t_phase, .x_phase,
    .addr_miscompare, .check_error, .address_mismatch_flag);
  adapter_model adapter (.core_clk, .rstn, .start, .lines, .word, .cs_active,
    .cs_request, .cs_ctl, .in_bus, .io_data);
  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // register port, one strobe cycle each
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  // one steal; compare word switched in only once the steal is under way
  task automatic steal(input logic [2:0] l, input logic [15:0] w, input logic [15:0] cmp);
    logic [15:0] pre;
    int seen;
    int done;
    logic miss;
    pre = exp_addr;
    // chain check lines with a wrong first word must miscompare
    miss = (l == 3'b110) && (cmp != pre);
    seen = 0;
    done = 0;
    errs = 0;
    @(posedge core_clk);
    lines <= l;
    word <= w;
    @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    for (int i = 0; i < 40 && done == 0; i++) begin
      @(negedge core_clk);
      if (cs_active === 1'b1 && seen == 0) `CHK({t_phase, x_phase}, 6'h00)
      if (cs_active === 1'b1) seen = 1;
      if (cs_active === 1'b1 && x_phase === cs_pkg::PH_4) `CHK(storage_addr, pre)
      if (cs_active === 1'b1 && x_phase === cs_pkg::PH_4) `CHK(addr_miscompare, miss)
      if (check_error === 1'b1) errs++;
      if (seen == 1 && cs_active === 1'b0) done = 1;
      @(posedge core_clk);
      // last edge left to the restore below, one driver write per step
      if (seen == 1 && done == 0) chan_data_bus <= cmp;
    end
    `CHK(done, 1);
    lines <= 3'h0;
    chan_data_bus <= pre;
    exp_buf = pre;
  endtask
  task automatic regs_check;
    rd(cs_pkg::OFS_CTRL, v);
    `CHK(v, 16'h0000);
    rd(cs_pkg::OFS_ADDR, v);
    `CHK(v, cs_pkg::ADDR_RESET);
    rd(4'hf, v);
    `CHK(v, 16'h0000);
    wr(cs_pkg::OFS_CTRL, 16'h0001);
    wr(cs_pkg::OFS_ADDR, 16'hf00f);
    wr(cs_pkg::OFS_BUFFER, 16'hffff);
    rd(cs_pkg::OFS_ADDR, v);
    `CHK(v, 16'hf00f);
    rd(cs_pkg::OFS_BUFFER, v);
    `CHK(v, 16'h0000);
  endtask
  // lines 01x idle: cleared at phase 3 then loaded, so old bits must vanish
  task automatic set_reset_check;
    @(posedge core_clk);
    lines <= 3'b010;
    chan_data_bus <= 16'h0a5c;
    repeat (20) @(posedge core_clk);
    lines <= 3'h0;
    chan_data_bus <= exp_buf;
    repeat (3) @(posedge core_clk);
    rd(cs_pkg::OFS_ADDR, v);
    `CHK(v, 16'h0a5c);
    exp_addr = 16'h0a5c;
  endtask
  task automatic decode_table_check;
    logic [2:0] codes [5] = '{3'b000, 3'b100, 3'b111, 3'b001, 3'b101};
    logic [15:0] w;
    for (int i = 0; i < 5; i++) begin
      w = 16'h1100 + 16'(i);
      steal(codes[i], w, exp_addr);
      if (codes[i] != 3'b101) exp_addr++;
      if (!codes[i][2] && codes[i][0]) exp_out = w;
      if (!codes[i][1] && codes[i][0]) exp_x = w ^ 16'h5a5a;
      rd(cs_pkg::OFS_ADDR, v);
      `CHK(v, exp_addr);
      `CHK(out_bus, exp_out);
      `CHK(xfer_reg, exp_x);
      `CHK(errs, 0);
    end
  endtask
  // matching first word passes; a wrong one errors once and sets the flag
  task automatic chain_check;
    steal(3'b110, 16'h2200, exp_addr);
    exp_addr++;
    `CHK(errs, 0);
    steal(3'b110, 16'h2201, ~exp_addr);
    exp_addr++;
    `CHK(errs, 1);
    repeat (10) @(posedge core_clk);
    `CHK(address_mismatch_flag, 1'b1);
    rd(cs_pkg::OFS_STATUS, v);
    `CHK(v[0], 1'b1);
    wr(cs_pkg::OFS_STATUS, 16'h0001);
    rd(cs_pkg::OFS_STATUS, v);
    `CHK(v[0], 1'b0);
    rd(cs_pkg::OFS_ADDR, v);
    `CHK(v, exp_addr);
  endtask
  // stuck-run guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    rstn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    start = 1'b0;
    lines = 3'h0;
    word = 16'h0000;
    chan_data_bus = 16'h0000;
    exp_addr = 16'h0000;
    exp_buf = 16'h0000;
    exp_out = 16'h0000;
    exp_x = 16'h0000;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    regs_check();
    set_reset_check();
    decode_table_check();
    chain_check();
    print_verdict();
  end
endmodule
